// [verilog/rcs_top.v]
// What this block does
// RQ1: Source LOW clocks outputs from reference
// RQ2: Reference mode: A,C drive reference; B,D tristate
// RQ3: Reference mode: B,D true pins pick master
// RQ4: A and C reference copies differ in phase
// RQ5: Source MID: each pair follows own recovered
// RQ6: Recovered clocks toggle at 1/20 or 1/10
// RQ7: Dual bonding HIGH: A from A/B, C from C/D
// RQ8: Quad bonding HIGH: one chosen clock on A,C
// RQ9: Independent HIGH: chosen clock on A,C too
// RQ10: Routed clocks at character or half rate
// RQ11: Multi-device bonding sets source LOW
// RQ12: Reframe allow enables all four framers
// RQ13: Two three-level mode inputs give nine modes
// RQ14: Framing LOW: positive comma only
// RQ15: Framing MID: both comma disparities
// RQ16: Framing HIGH: both K28.5 disparities
// RQ17: Rate HIGH halves clock; LOW character rate
// RQ18: Rate ignored in reference mode
// RQ19: Selects decode to stable static levels
//
// Implementation choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "rcs_defs.vh"
module rcs_top (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Asynchronous reframe pin
  input wire reframe_allow,
  // Framer character stream (10-bit window under test)
  input wire [9:0] rx_char_window,
  // Master select pins, three-level: {is_high, is_mid}
  input wire [1:0] master_select_b_pin,
  input wire [1:0] master_select_d_pin,
  // Character clock pairs {true, complement} with enables
  output reg [1:0] rx_char_clock_a_pair,
  output reg [1:0] rx_char_clock_b_pair,
  output reg [1:0] rx_char_clock_c_pair,
  output reg [1:0] rx_char_clock_d_pair,
  output reg rx_char_clock_a_oe,
  output reg rx_char_clock_b_oe,
  output reg rx_char_clock_c_oe,
  output reg rx_char_clock_d_oe,
  // Framer controls
  output reg [3:0] framer_enable,
  output reg framing_hit
);
  reg [31:0] ctrl;
  wire [1:0] rx_clock_source_select = ctrl[`RCS_CTRL_CKSEL_LSB+1:`RCS_CTRL_CKSEL_LSB];
  wire [1:0] mode_hi = ctrl[`RCS_CTRL_RXMODE1_LSB+1:`RCS_CTRL_RXMODE1_LSB];
  wire [1:0] mode_lo = ctrl[`RCS_CTRL_RXMODE0_LSB+1:`RCS_CTRL_RXMODE0_LSB];
  wire [1:0] framing_char_select = ctrl[`RCS_CTRL_FRAMCH_LSB+1:`RCS_CTRL_FRAMCH_LSB];
  wire rx_clock_rate_select = ctrl[`RCS_CTRL_RATE_BIT];
  wire [1:0] sel_b;
  wire [1:0] sel_d;
  reg rf_meta;
  reg rf_sync;
  reg [3:0] rx_operating_mode;
  reg [3:0] ref_cnt;
  reg ref_clk;
  reg ref_clk_late;
  reg [3:0] rec_cnt [0:3];
  reg [3:0] rec_char;
  reg [3:0] rec_half;
  reg [3:0] rec_clk;
  reg routed;
  reg routed_a;
  reg routed_c;
  reg [1:0] pick;
  reg next_hit;
  reg aw_hold;
  reg w_hold;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  integer i;

  // Master select pins are off-domain: synchronise and decode
  rcs_sync3 u_sync_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(master_select_b_pin),
    .level(sel_b)
  );
  rcs_sync3 u_sync_d (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw(master_select_d_pin),
    .level(sel_d)
  );

  // Mode decode and framing comparison
  always @* begin
    rx_operating_mode = {2'h0, mode_hi} * 4'h3 + {2'h0, mode_lo}; // [RQ13]
    pick = {sel_d == `RCS_LVL_HIGH, sel_b == `RCS_LVL_HIGH};
    case (framing_char_select)
      `RCS_LVL_LOW: next_hit = rx_char_window[9:3] == `RCS_COMMA_POS; // [RQ14]
      `RCS_LVL_MID: next_hit = (rx_char_window[9:3] == `RCS_COMMA_POS) ||
        (rx_char_window[9:3] == `RCS_COMMA_NEG); // [RQ15]
      default: next_hit = (rx_char_window == `RCS_K285_POS) ||
        (rx_char_window == `RCS_K285_NEG); // [RQ16]
    endcase
  end

  // Clock generation: reference divider and four recovered clocks
  always @(posedge aclk) begin
    if (!aresetn) begin
      ref_cnt <= 4'h0;
      ref_clk <= 1'b0;
      ref_clk_late <= 1'b0;
      // Odd channels start in antiphase, keeping the A/B and C/D channel choice observable
      rec_char <= `RCS_REC_PHASE_RESET;
      rec_half <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        rec_cnt[i] <= 4'h0;
      end
    end else begin
      if (ref_cnt == `RCS_REF_HALF - 4'h1) begin
        ref_cnt <= 4'h0;
        ref_clk <= ~ref_clk;
      end else begin
        ref_cnt <= ref_cnt + 4'h1;
      end
      ref_clk_late <= ref_clk; // [RQ4]
      for (i = 0; i < 4; i = i + 1) begin
        // Recovered clocks toggle continuously, all channels on the same cycles
        if (rec_cnt[i] >= `RCS_REC_HALF_CHAR - 4'h1) begin
          rec_cnt[i] <= 4'h0;
          rec_char[i] <= ~rec_char[i]; // [RQ6]
          if (rec_char[i]) begin
            rec_half[i] <= ~rec_half[i];
          end
        end else begin
          rec_cnt[i] <= rec_cnt[i] + 4'h1 + i[3:0];
        end
      end
    end
  end

  // Rate choice: half character rate when HIGH
  always @* begin
    rec_clk = rx_clock_rate_select ? rec_half : rec_char; // [RQ17] [RQ10]
    routed = rec_clk[pick];
    routed_a = (rx_operating_mode == 4'h3 || rx_operating_mode == 4'h5) ?
      rec_clk[{1'b0, pick[0]}] : routed; // [RQ7] [RQ8] [RQ9]
    routed_c = (rx_operating_mode == 4'h3 || rx_operating_mode == 4'h5) ?
      rec_clk[{1'b1, pick[1]}] : routed; // [RQ7]
  end

  // Output clock steering
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_char_clock_a_pair <= 2'h1;
      rx_char_clock_b_pair <= 2'h1;
      rx_char_clock_c_pair <= 2'h1;
      rx_char_clock_d_pair <= 2'h1;
      rx_char_clock_a_oe <= 1'b0;
      rx_char_clock_b_oe <= 1'b0;
      rx_char_clock_c_oe <= 1'b0;
      rx_char_clock_d_oe <= 1'b0;
    end else begin
      case (rx_clock_source_select)
        `RCS_LVL_LOW: begin
          // Reference drives outputs; rate select not read here [RQ1] [RQ18]
          rx_char_clock_a_pair <= {ref_clk, ~ref_clk}; // [RQ2]
          rx_char_clock_c_pair <= {ref_clk_late, ~ref_clk_late}; // [RQ4]
          rx_char_clock_a_oe <= 1'b1;
          rx_char_clock_c_oe <= 1'b1;
          rx_char_clock_b_oe <= 1'b0; // [RQ2] [RQ3]
          rx_char_clock_d_oe <= 1'b0;
        end
        `RCS_LVL_MID: begin
          rx_char_clock_a_pair <= {rec_clk[0], ~rec_clk[0]}; // [RQ5]
          rx_char_clock_b_pair <= {rec_clk[1], ~rec_clk[1]};
          rx_char_clock_c_pair <= {rec_clk[2], ~rec_clk[2]};
          rx_char_clock_d_pair <= {rec_clk[3], ~rec_clk[3]};
          rx_char_clock_a_oe <= 1'b1;
          rx_char_clock_b_oe <= 1'b1;
          rx_char_clock_c_oe <= 1'b1;
          rx_char_clock_d_oe <= 1'b1;
        end
        default: begin
          // B and D true pins are select inputs here
          rx_char_clock_a_pair <= {routed_a, ~routed_a}; // [RQ10]
          rx_char_clock_c_pair <= {routed_c, ~routed_c};
          rx_char_clock_a_oe <= 1'b1;
          rx_char_clock_c_oe <= 1'b1;
          rx_char_clock_b_oe <= 1'b0;
          rx_char_clock_d_oe <= 1'b0;
        end
      endcase
    end
  end

  // Reframe enable and framer hit
  always @(posedge aclk) begin
    if (!aresetn) begin
      rf_meta <= 1'b0;
      rf_sync <= 1'b0;
      framer_enable <= 4'h0;
      framing_hit <= 1'b0;
    end else begin
      rf_meta <= reframe_allow;
      rf_sync <= rf_meta;
      framer_enable <= {4{rf_sync}}; // [RQ12]
      framing_hit <= rf_sync & next_hit;
    end
  end

  // AXI4-Lite slave: write path
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RCS_RESP_OKAY;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      ctrl <= `RCS_CTRL_RESET;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (aw_hold && w_hold && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        if (aw_addr == `RCS_OFF_CTRL) begin
          ctrl <= {23'h000000, w_data[8:0]};
          s_axi_bresp <= `RCS_RESP_OKAY;
        end else if (aw_addr == `RCS_OFF_MODE || aw_addr == `RCS_OFF_STATUS ||
            aw_addr == `RCS_OFF_PATTERN) begin
          s_axi_bresp <= `RCS_RESP_OKAY;
        end else begin
          s_axi_bresp <= `RCS_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite slave: read path
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RCS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RCS_RESP_OKAY;
        case (s_axi_araddr)
          `RCS_OFF_CTRL: s_axi_rdata <= ctrl;
          `RCS_OFF_MODE: s_axi_rdata <= {28'h0000000, rx_operating_mode};
          `RCS_OFF_STATUS: s_axi_rdata <= {22'h000000, framing_hit, rf_sync,
            sel_d, sel_b, framer_enable};
          `RCS_OFF_PATTERN: s_axi_rdata <= {22'h000000, rx_char_window};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RCS_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule // rcs_top

// [verilog/rcs_defs.vh]
`ifndef RCS_DEFS_VH
`define RCS_DEFS_VH
// Three-level select encoding
`define RCS_LVL_LOW 2'h0
`define RCS_LVL_MID 2'h1
`define RCS_LVL_HIGH 2'h2
// Register byte offsets
`define RCS_OFF_CTRL 8'h00
`define RCS_OFF_MODE 8'h04
`define RCS_OFF_STATUS 8'h08
`define RCS_OFF_PATTERN 8'h0C
// CTRL fields
`define RCS_CTRL_CKSEL_LSB 0
`define RCS_CTRL_RXMODE0_LSB 2
`define RCS_CTRL_RXMODE1_LSB 4
`define RCS_CTRL_FRAMCH_LSB 6
`define RCS_CTRL_RATE_BIT 8
`define RCS_CTRL_RESET 32'h00000000
// Timing: reference divider (reference clock = aclk / (2 * half period))
`define RCS_REF_HALF 4'h1
// Recovered clock half period in aclk cycles, the same for every channel
`define RCS_REC_HALF_CHAR 4'h2
// Recovered clock start phases: odd channels start in antiphase
`define RCS_REC_PHASE_RESET 4'h5
// Comma patterns (7 bits of 10-bit char) and full 10-bit K28.5 chars, positive and negative
`define RCS_COMMA_POS 7'h7C
`define RCS_COMMA_NEG 7'h03
`define RCS_K285_POS 10'h0FA
`define RCS_K285_NEG 10'h305
// Bus responses
`define RCS_RESP_OKAY 2'h0
`define RCS_RESP_SLVERR 2'h2
`endif

// [verilog/rcs_sync3.v]
`timescale 1ns/1ps
`include "rcs_defs.vh"
// Two-flop synchroniser plus three-level decode of a two-wire select
module rcs_sync3 (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Raw select wires: {is_high, is_mid}
  input wire [1:0] raw,
  // Decoded level
  output reg [1:0] level
);
  reg [1:0] meta;
  reg [1:0] stable;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta <= 2'h0;
      stable <= 2'h0;
      level <= `RCS_LVL_LOW;
    end else begin
      meta <= raw;
      stable <= meta;
      if (stable[1]) begin // [RQ19]
        level <= `RCS_LVL_HIGH;
      end else if (stable[0]) begin
        level <= `RCS_LVL_MID;
      end else begin
        level <= `RCS_LVL_LOW;
      end
    end
  end
endmodule // rcs_sync3

// [test/rcs_chk.sv]
`timescale 1ns/1ps
module rcs_chk (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Framer side
  input wire reframe_allow,
  input wire [3:0] framer_enable,
  input wire framing_hit,
  // Clock pins
  input wire [1:0] rx_char_clock_a_pair,
  input wire [1:0] rx_char_clock_c_pair,
  input wire rx_char_clock_a_oe,
  input wire rx_char_clock_b_oe,
  input wire rx_char_clock_c_oe,
  input wire rx_char_clock_d_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  fe_uniform_a: assert property (framer_enable == 4'h0 || framer_enable == 4'hF)
    else $error("framer enables differ");
  fe_rise_a: assert property (reframe_allow [*6] |-> framer_enable == 4'hF)
    else $error("framers not enabled");
  fe_fall_a: assert property ((!reframe_allow) [*6] |-> framer_enable == 4'h0)
    else $error("framers not disabled");
  hit_gate_a: assert property (framing_hit |->
    (framer_enable == 4'hF || $past(framer_enable) == 4'hF) or ##1 framer_enable == 4'hF)
    else $error("hit while framers off");
  bd_oe_a: assert property (rx_char_clock_b_oe == rx_char_clock_d_oe)
    else $error("b and d enables differ");
  ac_oe_a: assert property (rx_char_clock_a_oe == rx_char_clock_c_oe)
    else $error("a and c enables differ");
  b_needs_a_a: assert property (rx_char_clock_b_oe |-> rx_char_clock_a_oe)
    else $error("b driven without a");
  a_comp_a: assert property (rx_char_clock_a_oe |-> ^rx_char_clock_a_pair)
    else $error("a pair not complementary");
  c_toggle_a: assert property (rx_char_clock_c_oe |->
    ##[1:16] ($changed(rx_char_clock_c_pair) || !rx_char_clock_c_oe))
    else $error("c clock stalled");
  rst_quiet_a: assert property ($rose(aresetn) |-> !rx_char_clock_a_oe && framer_enable == 4'h0)
    else $error("outputs active after reset");
endmodule // rcs_chk

// [test/rcs_host_rx.sv]
`timescale 1ns/1ps
module rcs_host_rx (
  // Clock
  input wire aclk,
  // Static choices
  input wire [1:0] sel_b_cfg,
  input wire [1:0] sel_d_cfg,
  // Device clock pins
  input wire [1:0] rx_char_clock_a_pair,
  input wire [1:0] rx_char_clock_c_pair,
  input wire rx_char_clock_b_oe,
  input wire rx_char_clock_d_oe,
  // Select pins and latch counts
  output reg [1:0] master_select_b_pin,
  output reg [1:0] master_select_d_pin,
  output integer rise_a,
  output integer rise_c
);
  reg prev_a = 1'b0;
  reg prev_c = 1'b0;
  initial begin
    master_select_b_pin = 2'h0;
    master_select_d_pin = 2'h0;
    rise_a = 0;
    rise_c = 0;
  end
  // Bonding stays inside one device, so any source setting is legal
  always @(posedge aclk) begin
    // While the device drives a pin, what we see there is noise
    master_select_b_pin <= rx_char_clock_b_oe ? ~master_select_b_pin : sel_b_cfg;
    master_select_d_pin <= rx_char_clock_d_oe ? ~master_select_d_pin : sel_d_cfg;
    prev_a <= rx_char_clock_a_pair[1];
    prev_c <= rx_char_clock_c_pair[1];
    // Data is latched on each rising true edge
    if (rx_char_clock_a_pair[1] && !prev_a) rise_a <= rise_a + 1;
    if (rx_char_clock_c_pair[1] && !prev_c) rise_c <= rise_c + 1;
  end
endmodule // rcs_host_rx

// [test/rcs_top_tb_top.sv]
`timescale 1ns/1ps
`include "rcs_defs.vh"
module rcs_top_tb_top;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] awaddr = 8'h00, araddr = 8'h00;
  reg [31:0] wdata = 32'h0, r;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, rfa = 1'b0;
  reg [9:0] win = 10'h000;
  reg [1:0] sel_b = 2'h0, sel_d = 2'h0;
  wire awready, wready, bvalid, arready, rvalid, oa, ob, oc, od, hit;
  wire [1:0] bresp, rresp, msb, msd, pa, pb, pc, pd;
  wire [31:0] rdata;
  wire [3:0] fen;
  integer ra, rc, i, j, ga, gc, n, err_total = 0, check_count = 0, seed = 32'h0823E99A;
  reg [33:0] exp_q[$];
  reg [31:0] msk_q[$];
  reg [1:0] bq[$];
  always #2 aclk = ~aclk;
  rcs_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .reframe_allow(rfa), .rx_char_window(win), .master_select_b_pin(msb),
    .master_select_d_pin(msd), .rx_char_clock_a_pair(pa), .rx_char_clock_b_pair(pb),
    .rx_char_clock_c_pair(pc), .rx_char_clock_d_pair(pd), .rx_char_clock_a_oe(oa),
    .rx_char_clock_b_oe(ob), .rx_char_clock_c_oe(oc), .rx_char_clock_d_oe(od),
    .framer_enable(fen), .framing_hit(hit));
  rcs_host_rx u_host (.aclk(aclk), .sel_b_cfg(sel_b), .sel_d_cfg(sel_d),
    .rx_char_clock_a_pair(pa), .rx_char_clock_c_pair(pc), .rx_char_clock_b_oe(ob),
    .rx_char_clock_d_oe(od), .master_select_b_pin(msb), .master_select_d_pin(msd),
    .rise_a(ra), .rise_c(rc));
  task automatic chk(input string nm, input [33:0] e, input [33:0] g);
    check_count = check_count + 1;
    if (e !== g) begin
      err_total = err_total + 1;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task finish_test;
    if (err_total == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge aclk);
    bq.push_back((a == `RCS_OFF_CTRL || a == `RCS_OFF_MODE || a == `RCS_OFF_STATUS ||
      a == `RCS_OFF_PATTERN) ? `RCS_RESP_OKAY : `RCS_RESP_SLVERR);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, input [33:0] e, input [31:0] m);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    exp_q.push_back(e);
    msk_q.push_back(m);
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  // Read checker: oldest note against each returned beat
  always @(posedge aclk) if (rvalid === 1'b1 && rready)
    chk("read", exp_q.pop_front(), {rresp, rdata & msk_q.pop_front()});
  // Write response checker: oldest note against each response
  always @(posedge aclk) if (bvalid === 1'b1 && bready)
    chk("bresp", bq.pop_front(), bresp);
  task wt;
    repeat (8) @(posedge aclk);
  endtask
  task automatic rate(input integer e);
    ga = ra;
    gc = rc;
    repeat (32) @(posedge aclk);
    chk("rises_a", e, ra - ga);
    chk("rises_c", e, rc - gc);
  endtask
  // Counts cycles where the a and c clocks disagree
  task automatic ac(input eq);
    n = 0;
    repeat (16) begin
      @(posedge aclk);
      if (pa !== pc) n = n + 1;
    end
    chk("ac_same", eq, n == 0);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`RCS_OFF_CTRL, 34'h0, 32'hFFFFFFFF);
    rd(8'h10, {`RCS_RESP_SLVERR, 32'h0}, 32'hFFFFFFFF);
    wr(8'h10, 32'h1);
    wr(`RCS_OFF_MODE, 32'h5);
    rd(`RCS_OFF_MODE, 34'h0, 32'hF);
    sel_b <= 2'h1;
    sel_d <= 2'h2;
    wt;
    chk("oe", 4'hA, {oa, ob, oc, od});
    ac(1'b0);
    rd(`RCS_OFF_STATUS, 34'h90, 32'hF0);
    rate(16);
    wr(`RCS_OFF_CTRL, 32'h100);
    rate(16);
    wr(`RCS_OFF_CTRL, 32'h1);
    wt;
    chk("oe", 4'hF, {oa, ob, oc, od});
    chk("b_pair", {pa[0], pa[1]}, pb);
    chk("d_pair", {pc[0], pc[1]}, pd);
    rate(8);
    wr(`RCS_OFF_CTRL, 32'h101);
    wt;
    rate(4);
    for (i = 0; i < 3; i = i + 1) for (j = 0; j < 3; j = j + 1) begin
      wr(`RCS_OFF_CTRL, 32'h2 | (j << 2) | (i << 4));
      rd(`RCS_OFF_MODE, i * 3 + j, 32'hF);
      chk("oe", 4'hA, {oa, ob, oc, od});
    end
    for (i = 0; i < 4; i = i + 1) begin
      sel_b <= i[0] ? 2'h2 : 2'h0;
      sel_d <= i[1] ? 2'h2 : 2'h0;
      wr(`RCS_OFF_CTRL, 32'h22);
      wt;
      ac(1'b1);
      wr(`RCS_OFF_CTRL, 32'h2);
      wt;
      ac(1'b1);
      wr(`RCS_OFF_CTRL, 32'h12);
      wt;
      ac(i[0] == i[1]);
    end
    wr(`RCS_OFF_CTRL, 32'h12);
    wt;
    rate(8);
    wr(`RCS_OFF_CTRL, 32'h112);
    wt;
    rate(4);
    rfa <= 1'b1;
    wt;
    rd(`RCS_OFF_STATUS, 34'h10F, 32'h10F);
    for (i = 0; i < 3; i = i + 1) begin
      wr(`RCS_OFF_CTRL, i << 6);
      for (j = 0; j < 4; j = j + 1) begin
        r = $random(seed);
        win <= j == 0 ? {`RCS_COMMA_POS, r[2:0]} : j == 1 ? {`RCS_COMMA_NEG, r[2:0]} :
          j == 2 ? `RCS_K285_POS : `RCS_K285_NEG;
        repeat (4) @(posedge aclk);
        chk("hit", 12'hC31 >> (i * 4 + j) & 12'h1, hit);
      end
    end
    wr(`RCS_OFF_CTRL, 32'h0);
    rfa <= 1'b0;
    win <= {`RCS_COMMA_POS, r[5:3]};
    wt;
    chk("hit_off", 1'b0, hit);
    rd(`RCS_OFF_STATUS, 34'h0, 32'h10F);
    wt;
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    err_total = err_total + 1;
    finish_test;
  end
endmodule // rcs_top_tb_top
bind rcs_top rcs_chk u_chk (.aclk(aclk), .aresetn(aresetn), .reframe_allow(reframe_allow),
  .framer_enable(framer_enable), .framing_hit(framing_hit),
  .rx_char_clock_a_pair(rx_char_clock_a_pair), .rx_char_clock_c_pair(rx_char_clock_c_pair),
  .rx_char_clock_a_oe(rx_char_clock_a_oe), .rx_char_clock_b_oe(rx_char_clock_b_oe),
  .rx_char_clock_c_oe(rx_char_clock_c_oe), .rx_char_clock_d_oe(rx_char_clock_d_oe));
